// ---- rtl/alarm_relay_timing.sv ----
// Two-channel alarm relay timing block with lamps and registers.
// Assumes a synchronous process value input and a plain register port.
`timescale 1ns/100ps
`default_nettype none
module alarm_relay_timing
    import alarm_relay_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [DATA_W-1:0] pv,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   first_alarm_lamp,
    output logic                   second_alarm_lamp,
    output logic                   first_alarm_relay,
    output logic                   second_alarm_relay
);

    // Width of the second prescaler
    localparam int TCW = $clog2(TICKS);

    // Whole state of the block
    typedef struct packed {
        logic [NCH-1:0][DATA_W-1:0] sp;     // Set points
        logic [NCH-1:0][DATA_W-1:0] hys;    // Hysteresis bands
        logic [NCH-1:0][1:0]        func;   // Alarm functions
        logic [NCH-1:0][TIME_W-1:0] on_t;   // Operation times
        logic [NCH-1:0][TIME_W-1:0] dly_t;  // Delay times
        tstate_e [NCH-1:0]          st;     // Timing states
        logic [NCH-1:0][TIME_W-1:0] cnt;    // Second counters
        logic [NCH-1:0]             relay;  // Relay drives
        logic [TCW-1:0]             pre;    // Prescaler
        logic                       tick;   // One-second pulse
        logic [DATA_W-1:0]          rdata;  // Read data
    } top_s;

    top_s               s_r;                // Current state
    top_s               s_nxt;              // Next state
    logic [NCH-1:0]     cond_r;             // Registered conditions
    logic [ADDR_W-1:0]  base;               // Channel register base
    logic [TIME_W-1:0]  inc;                // Counter plus one
    logic [TIME_W-1:0]  wtime;              // Clamped time write

    // Condition comparators, one per channel
    for (genvar c = 0; c < NCH; c++) begin : g_cmp
        alarm_compare #(
            .DW        (DATA_W)
        ) u_cmp (
            .clk       (clk),
            .arst_n    (arst_n),
            .pv        (pv),
            .set_point (s_r.sp[c]),
            .band      (s_r.hys[c]),
            .func      (s_r.func[c]),
            .cond      (cond_r[c])
        );
    end

    // Register access, prescaler and relay timing machines
    always_comb begin
        s_nxt = s_r;
        base  = '0;
        inc   = '0;
        // Times above the top of range are clamped
        if (reg_wdata > TIME_MAX) begin
            wtime = TIME_MAX[TIME_W-1:0];
        end else begin
            wtime = reg_wdata[TIME_W-1:0];
        end

        // Free-running one-second prescaler
        if (s_r.pre == TCW'(TICKS - 1)) begin
            s_nxt.pre  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.pre  = s_r.pre + 1'b1;
            s_nxt.tick = 1'b0;
        end

        // Read data stand one cycle only; unmapped reads give zero
        s_nxt.rdata = '0;
        if (reg_rd && reg_addr == ADDR_STATUS) begin
            s_nxt.rdata[STAT_COND +: NCH]  = cond_r;
            s_nxt.rdata[STAT_RELAY +: NCH] = s_r.relay;
        end

        for (int c = 0; c < NCH; c++) begin
            base = ADDR_W'(c * CH_STRIDE);
            // Configuration writes
            if (reg_wr) begin
                if (reg_addr == base + FLD_SP) begin
                    s_nxt.sp[c] = reg_wdata;
                end
                if (reg_addr == base + FLD_FUNC) begin
                    s_nxt.func[c] = reg_wdata[1:0];
                end
                if (reg_addr == base + FLD_HYS) begin
                    s_nxt.hys[c] = reg_wdata;
                end
                if (reg_addr == base + FLD_ON) begin
                    s_nxt.on_t[c] = wtime;
                end
                if (reg_addr == base + FLD_DLY) begin
                    s_nxt.dly_t[c] = wtime;
                end
            end
            // Configuration reads
            if (reg_rd) begin
                if (reg_addr == base + FLD_SP) begin
                    s_nxt.rdata = s_r.sp[c];
                end
                if (reg_addr == base + FLD_FUNC) begin
                    s_nxt.rdata = DATA_W'(s_r.func[c]);
                end
                if (reg_addr == base + FLD_HYS) begin
                    s_nxt.rdata = s_r.hys[c];
                end
                if (reg_addr == base + FLD_ON) begin
                    s_nxt.rdata = DATA_W'(s_r.on_t[c]);
                end
                if (reg_addr == base + FLD_DLY) begin
                    s_nxt.rdata = DATA_W'(s_r.dly_t[c]);
                end
            end

            // Relay timing machine of this channel
            inc = s_r.cnt[c] + 1'b1;
            if (!cond_r[c]) begin
                // Condition gone: release and clear at once
                s_nxt.st[c]    = ST_IDLE;
                s_nxt.cnt[c]   = '0;
                s_nxt.relay[c] = 1'b0;
            end else begin
                unique case (s_r.st[c])
                    ST_IDLE: begin
                        s_nxt.cnt[c] = '0;
                        // Delay mode waits, every other mode starts on
                        if (s_r.on_t[c] == '0 && s_r.dly_t[c] != '0) begin
                            s_nxt.st[c]    = ST_DELAY;
                            s_nxt.relay[c] = 1'b0;
                        end else begin
                            s_nxt.st[c]    = ST_ON;
                            s_nxt.relay[c] = 1'b1;
                        end
                    end
                    ST_DELAY: begin
                        if (s_r.on_t[c] != '0 || s_r.dly_t[c] == '0) begin
                            // Mode changed while waiting
                            s_nxt.st[c]  = ST_IDLE;
                            s_nxt.cnt[c] = '0;
                        end else if (s_r.tick) begin
                            if (inc >= s_r.dly_t[c]) begin
                                s_nxt.st[c]    = ST_ON;
                                s_nxt.cnt[c]   = '0;
                                s_nxt.relay[c] = 1'b1;
                            end else begin
                                s_nxt.cnt[c] = inc;
                            end
                        end
                    end
                    ST_ON: begin
                        s_nxt.relay[c] = 1'b1;
                        // Zero operation time holds the relay on
                        if (s_r.on_t[c] != '0 && s_r.tick) begin
                            if (inc >= s_r.on_t[c]) begin
                                s_nxt.cnt[c]   = '0;
                                s_nxt.relay[c] = 1'b0;
                                if (s_r.dly_t[c] == '0) begin
                                    s_nxt.st[c] = ST_DONE;
                                end else begin
                                    s_nxt.st[c] = ST_PAUSE;
                                end
                            end else begin
                                s_nxt.cnt[c] = inc;
                            end
                        end
                    end
                    ST_PAUSE: begin
                        if (s_r.on_t[c] == '0 || s_r.dly_t[c] == '0) begin
                            s_nxt.st[c]  = ST_IDLE;
                            s_nxt.cnt[c] = '0;
                        end else if (s_r.tick) begin
                            if (inc >= s_r.dly_t[c]) begin
                                s_nxt.st[c]    = ST_ON;
                                s_nxt.cnt[c]   = '0;
                                s_nxt.relay[c] = 1'b1;
                            end else begin
                                s_nxt.cnt[c] = inc;
                            end
                        end
                    end
                    ST_DONE: begin
                        // Pulse spent: stay released until condition ends or the mode changes
                        s_nxt.relay[c] = 1'b0;
                        if (s_r.on_t[c] == '0 || s_r.dly_t[c] != '0) begin
                            s_nxt.st[c] = ST_IDLE;
                        end
                    end
                    default: begin
                        s_nxt.st[c]    = ST_IDLE;
                        s_nxt.cnt[c]   = '0;
                        s_nxt.relay[c] = 1'b0;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r       <= '0;
            s_r.sp    <= '{default: SP_RST};
            s_r.hys   <= '{default: HYS_RST};
            s_r.func  <= '{default: FUNC_RST};
            s_r.on_t  <= '{default: TIME_RST};
            s_r.dly_t <= '{default: TIME_RST};
            s_r.st    <= '{default: ST_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Lamps follow the condition alone, relays come from timing
    assign first_alarm_lamp   = cond_r[0];
    assign second_alarm_lamp  = cond_r[1];
    assign first_alarm_relay  = s_r.relay[0];
    assign second_alarm_relay = s_r.relay[1];
    assign reg_rdata          = s_r.rdata;

    // Checks per channel
    for (genvar c = 0; c < NCH; c++) begin : g_chk
        property p_relay_cond;
            @(posedge clk) disable iff (!arst_n)
            s_r.relay[c] |-> $past(cond_r[c]);
        endproperty
        a_relay_cond: assert property (p_relay_cond)
            else $error("relay on without alarm condition");

        property p_release;
            @(posedge clk) disable iff (!arst_n)
            !cond_r[c] |=> (!s_r.relay[c] && s_r.cnt[c] == '0);
        endproperty
        a_release: assert property (p_release)
            else $error("relay or timer kept after condition fell");

        property p_follow;
            @(posedge clk) disable iff (!arst_n)
            (cond_r[c] && s_r.on_t[c] == '0 && s_r.dly_t[c] == '0)[*2]
            |=> s_r.relay[c];
        endproperty
        a_follow: assert property (p_follow)
            else $error("relay does not follow condition");

        property p_delay_quiet;
            @(posedge clk) disable iff (!arst_n)
            (s_r.st[c] == ST_DELAY) |-> !s_r.relay[c];
        endproperty
        a_delay_quiet: assert property (p_delay_quiet)
            else $error("relay on during delay");

        property p_delay_fire;
            @(posedge clk) disable iff (!arst_n)
            (s_r.st[c] == ST_DELAY && cond_r[c] && s_r.tick
             && s_r.on_t[c] == '0 && s_r.dly_t[c] != '0
             && s_r.cnt[c] + 1'b1 == s_r.dly_t[c])
            |=> s_r.relay[c] ##1 (s_r.relay[c] || !cond_r[c]);
        endproperty
        a_delay_fire: assert property (p_delay_fire)
            else $error("relay not on when delay ran out");

        property p_pulse_end;
            @(posedge clk) disable iff (!arst_n)
            (s_r.st[c] == ST_ON && cond_r[c] && s_r.tick
             && s_r.on_t[c] != '0 && s_r.dly_t[c] == '0
             && s_r.cnt[c] + 1'b1 == s_r.on_t[c])
            |=> (!s_r.relay[c] && s_r.st[c] == ST_DONE);
        endproperty
        a_pulse_end: assert property (p_pulse_end)
            else $error("pulse did not end after operation time");

        property p_osc_resume;
            @(posedge clk) disable iff (!arst_n)
            (s_r.st[c] == ST_PAUSE && cond_r[c] && s_r.tick
             && s_r.on_t[c] != '0 && s_r.dly_t[c] != '0
             && s_r.cnt[c] + 1'b1 == s_r.dly_t[c])
            |=> s_r.relay[c];
        endproperty
        a_osc_resume: assert property (p_osc_resume)
            else $error("oscillator did not resume");

        property p_off_dark;
            @(posedge clk) disable iff (!arst_n)
            (s_r.func[c] == FUNC_OFF) |=> !cond_r[c];
        endproperty
        a_off_dark: assert property (p_off_dark)
            else $error("disabled alarm shows a condition");
    end

endmodule : alarm_relay_timing
`default_nettype wire

// ---- rtl/alarm_relay_pkg.sv ----
// Constants shared by the alarm relay timing block.
// Assumes a 125 MHz system clock and 16-bit register words.
package alarm_relay_pkg;

    // Data, address and time widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int TIME_W = 10;
    localparam int NCH    = 2;

    // One-second tick derived from the clock rate
    localparam int CLK_HZ        = 125_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES   = TICK_PERIOD_S * CLK_HZ;

    // Longest operation or delay time in seconds
    localparam logic [DATA_W-1:0] TIME_MAX = 16'h03e8;

    // Per-channel register block: base is channel times stride
    localparam int CH_STRIDE = 5;
    localparam logic [ADDR_W-1:0] FLD_SP   = 4'h0;
    localparam logic [ADDR_W-1:0] FLD_FUNC = 4'h1;
    localparam logic [ADDR_W-1:0] FLD_HYS  = 4'h2;
    localparam logic [ADDR_W-1:0] FLD_ON   = 4'h3;
    localparam logic [ADDR_W-1:0] FLD_DLY  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'ha;

    // Status word layout
    localparam int STAT_COND  = 0;
    localparam int STAT_RELAY = 2;

    // Alarm function codes
    localparam logic [1:0] FUNC_OFF   = 2'h0;
    localparam logic [1:0] FUNC_BELOW = 2'h1;
    localparam logic [1:0] FUNC_ABOVE = 2'h2;
    localparam logic [1:0] FUNC_BAND  = 2'h3;

    // Reset values
    localparam logic [DATA_W-1:0] SP_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] HYS_RST  = 16'h0000;
    localparam logic [1:0]        FUNC_RST = 2'h0;
    localparam logic [TIME_W-1:0] TIME_RST = 10'h000;

    // Relay timing states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_DELAY = 5'h02,
        ST_ON    = 5'h04,
        ST_PAUSE = 5'h08,
        ST_DONE  = 5'h10
    } tstate_e;

endpackage : alarm_relay_pkg

// ---- rtl/alarm_compare.sv ----
// Alarm condition comparator for one channel.
// Assumes signed process value and registered configuration.
`timescale 1ns/100ps
`default_nettype none
module alarm_compare
    import alarm_relay_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [DW-1:0] pv,
    input  wire logic [DW-1:0] set_point,
    input  wire logic [DW-1:0] band,
    input  wire logic [1:0]    func,
    output logic               cond
);

    // Whole state of the comparator
    typedef struct packed {
        logic cond;                 // Registered alarm condition
    } cmp_s;

    cmp_s                s_r;       // Current state
    cmp_s                s_nxt;     // Next state
    logic signed [DW+1:0] pv_w;     // Widened process value
    logic signed [DW+1:0] sp_w;     // Widened set point
    logic signed [DW+1:0] bd_w;     // Widened band half width
    logic signed [DW+1:0] lo_w;     // Band lower edge
    logic signed [DW+1:0] hi_w;     // Band upper edge

    // Widen into signed variables so band edges cannot overflow and
    // every comparison below stays signed
    always_comb begin
        pv_w  = {{2{pv[DW-1]}}, pv};
        sp_w  = {{2{set_point[DW-1]}}, set_point};
        bd_w  = {{2{band[DW-1]}}, band};
        lo_w  = sp_w - bd_w;
        hi_w  = sp_w + bd_w;
        s_nxt = s_r;
        // Strict comparisons against set point or band edges
        unique case (func)
            FUNC_OFF:   s_nxt.cond = 1'b0;
            FUNC_BELOW: s_nxt.cond = pv_w < sp_w;
            FUNC_ABOVE: s_nxt.cond = pv_w > sp_w;
            FUNC_BAND:  s_nxt.cond = (pv_w < lo_w) || (pv_w > hi_w);
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cond = s_r.cond;

endmodule : alarm_compare
`default_nettype wire

// ---- verification/relay_lamp_model.sv ----
// Relay driver stage on the far side of the alarm timing block.
// Assumes relay drive levels from the block and one clock with async reset.
`timescale 1ns/100ps
`default_nettype none
module relay_lamp_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] relay,
    output logic      [7:0] closures0,
    output logic      [7:0] closures1
);
    logic [1:0] relay_r;  // Coil drive seen at the last edge

    // Count contact closures, one for each rising coil drive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            relay_r   <= 2'h0;
            closures0 <= 8'h00;
            closures1 <= 8'h00;
        end else begin
            relay_r <= relay;
            if (relay[0] && !relay_r[0]) begin  // First coil pulls in
                closures0 <= closures0 + 8'h01;
            end
            if (relay[1] && !relay_r[1]) begin  // Second coil pulls in
                closures1 <= closures1 + 8'h01;
            end
        end
    end
endmodule : relay_lamp_model
`default_nettype wire

// ---- verification/tb_alarm_relay_timing.sv ----
// Self-checking bench for the alarm relay timing block.
// Assumes a shortened second of TK clock cycles and the relay model.
`timescale 1ns/100ps
`default_nettype none
module tb_alarm_relay_timing
    import alarm_relay_pkg::*;
;
    localparam int TK = 8;                   // Cycles per simulated second
    logic              clk;                  // System clock
    logic              arst_n;               // Async reset, active low
    logic [DATA_W-1:0] pv;                   // Process value
    logic [ADDR_W-1:0] addr;                 // Register index
    logic [DATA_W-1:0] wdata;                // Register write data
    logic              wr;                   // Write strobe
    logic              rd;                   // Read strobe
    logic [DATA_W-1:0] rdata;                // Register read data
    logic [1:0]        lamp;                 // Indicator lamps
    logic [1:0]        relay;                // Relay drives
    logic [7:0]        cl0;                  // First relay closures
    logic [7:0]        cl1;                  // Second relay closures
    logic [DATA_W-1:0] d;                    // Last read word
    logic [7:0]        c0;                   // Closure count snapshot
    logic [2:0]        tbl [4];              // Lamp per function and pv
    logic [DATA_W-1:0] pvs [3];              // Test process values
    int                error_cnt;            // Mismatches seen
    int                compares;             // Comparisons made
    int                n;                    // Measured cycles

    alarm_relay_timing #(.TICKS(TK)) i_alarm_relay_timing (
        .clk               (clk),
        .arst_n            (arst_n),
        .pv                (pv),
        .reg_addr          (addr),
        .reg_wdata         (wdata),
        .reg_wr            (wr),
        .reg_rd            (rd),
        .reg_rdata         (rdata),
        .first_alarm_lamp  (lamp[0]),
        .second_alarm_lamp (lamp[1]),
        .first_alarm_relay (relay[0]),
        .second_alarm_relay(relay[1])
    );

    relay_lamp_model i_relay_lamp_model (
        .clk      (clk),
        .arst_n   (arst_n),
        .relay    (relay),
        .closures0(cl0),
        .closures1(cl1)
    );

    // Free running clock
    always #4 clk = ~clk;

    // Print counts and verdict, then stop
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Compare one value against its expectation
    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Check that a measured count lies in a window
    task automatic in_range(input string what, input int lo, input int hi);
        check(what, {15'h0, (n >= lo && n <= hi)}, 16'h0001);
    endtask : in_range

    // One-cycle register write
    task automatic wr_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // One-cycle register read, data taken in the following cycle
    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Register index of a channel field
    function automatic logic [ADDR_W-1:0] fa(input int ch,
                                             input logic [ADDR_W-1:0] f);
        return ADDR_W'(ch * CH_STRIDE) + f;
    endfunction : fa

    // Program a whole channel
    task automatic cfg(input int ch, input logic [1:0] f,
                       input logic [DATA_W-1:0] sp, on, dl);
        wr_reg(fa(ch, FLD_SP), sp);
        wr_reg(fa(ch, FLD_FUNC), {14'h0, f});
        wr_reg(fa(ch, FLD_HYS), 16'h000a);
        wr_reg(fa(ch, FLD_ON), on);
        wr_reg(fa(ch, FLD_DLY), dl);
    endtask : cfg

    // Change the process value just after an edge
    task automatic set_pv(input logic [DATA_W-1:0] v);
        @(posedge clk);
        pv <= v;
    endtask : set_pv

    // Count cycles until a relay reaches a level, bounded
    task automatic wait_relay(input int ch, input logic v, input int lim);
        n = 0;
        #1;
        while (relay[ch] !== v) begin
            if (n == lim) begin
                error_cnt++;
                $display("timeout on relay %0d", ch);
                print_verdict();
            end
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_relay

    // Bound on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        clk       = 1'b0;
        arst_n    = 1'b0;
        pv        = '0;
        addr      = '0;
        wdata     = '0;
        wr        = 1'b0;
        rd        = 1'b0;
        error_cnt = 0;
        compares  = 0;
        tbl = '{3'b000, 3'b100, 3'b011, 3'b110};
        pvs = '{16'h0005, 16'h0014, 16'hffec};
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values of all five fields of both channels and an unmapped index
        for (int ch = 0; ch < NCH; ch++) begin
            for (int f = 0; f < 5; f++) begin
                rd_reg(fa(ch, ADDR_W'(f)));
                check("reset field", d, 16'h0000);
            end
        end
        rd_reg(4'hf);
        check("unmapped", d, 16'h0000);
        // Time clamp, function width, read-only status
        wr_reg(fa(0, FLD_ON), 16'h07d0);
        rd_reg(fa(0, FLD_ON));
        check("time clamp", d, TIME_MAX);
        wr_reg(fa(0, FLD_FUNC), 16'h0007);
        rd_reg(fa(0, FLD_FUNC));
        check("function", d, 16'h0003);
        wr_reg(fa(0, FLD_FUNC), 16'h0000);
        wr_reg(ADDR_STATUS, 16'hffff);
        rd_reg(ADDR_STATUS);
        check("status", d, 16'h0000);
        // Every function on the second channel, follow mode
        for (int f = 0; f < 4; f++) begin
            cfg(1, f[1:0], 16'h0000, 16'h0000, 16'h0000);
            for (int i = 0; i < 3; i++) begin
                set_pv(pvs[i]);
                repeat (3) @(posedge clk);
                #1 check("lamp1", {15'h0, lamp[1]}, {15'h0, tbl[f][i]});
                check("relay1", {15'h0, relay[1]}, {15'h0, tbl[f][i]});
                check("lamp0", {15'h0, lamp[0]}, 16'h0000);
            end
        end
        wr_reg(fa(1, FLD_FUNC), 16'h0000);
        // Follow mode timing on the first channel
        cfg(0, FUNC_ABOVE, 16'h0064, 16'h0000, 16'h0000);
        set_pv(16'h00c8);
        @(posedge clk);
        #1 check("lamp0", {15'h0, lamp[0]}, 16'h0001);
        check("relay0", {15'h0, relay[0]}, 16'h0000);
        @(posedge clk);
        #1 check("relay0", {15'h0, relay[0]}, 16'h0001);
        rd_reg(ADDR_STATUS);
        check("status", d, 16'h0005);
        set_pv(16'h0000);
        wait_relay(0, 1'b0, 3);
        // Delay mode
        wr_reg(fa(0, FLD_DLY), 16'h0002);
        set_pv(16'h00c8);
        wait_relay(0, 1'b1, 40);
        in_range("delay", TK, 2 * TK + 3);
        check("lamp0", {15'h0, lamp[0]}, 16'h0001);
        set_pv(16'h0000);
        wait_relay(0, 1'b0, 3);
        // Interrupted delay restarts from zero
        wr_reg(fa(0, FLD_DLY), 16'h0003);
        set_pv(16'h00c8);
        repeat (2 * TK) @(posedge clk);
        set_pv(16'h0000);
        repeat (3) @(posedge clk);
        set_pv(16'h00c8);
        wait_relay(0, 1'b1, 60);
        in_range("restart", 2 * TK, 3 * TK + 3);
        set_pv(16'h0000);
        // Single pulse
        wr_reg(fa(0, FLD_ON), 16'h0002);
        wr_reg(fa(0, FLD_DLY), 16'h0000);
        set_pv(16'h00c8);
        wait_relay(0, 1'b1, 3);
        wait_relay(0, 1'b0, 40);
        in_range("pulse", TK - 1, 2 * TK + 2);
        repeat (3 * TK) @(posedge clk);
        #1 check("relay0", {15'h0, relay[0]}, 16'h0000);
        check("lamp0", {15'h0, lamp[0]}, 16'h0001);
        set_pv(16'h0000);
        // Oscillator
        wr_reg(fa(0, FLD_ON), 16'h0001);
        wr_reg(fa(0, FLD_DLY), 16'h0002);
        c0 = cl0;
        set_pv(16'h00c8);
        wait_relay(0, 1'b1, 3);
        wait_relay(0, 1'b0, TK + 3);
        wait_relay(0, 1'b1, 40);
        in_range("off time", TK, 2 * TK + 2);
        wait_relay(0, 1'b0, TK + 3);
        wait_relay(0, 1'b1, 40);
        set_pv(16'h0000);
        wait_relay(0, 1'b0, 3);
        check("closures", {8'h00, cl0 - c0}, 16'h0003);
        check("lamp0", {15'h0, lamp[0]}, 16'h0000);
        check("relay1", {14'h0, relay[1], cl1 == 8'h00}, 16'h0000);
        print_verdict();
    end
endmodule : tb_alarm_relay_timing
`default_nettype wire
